/* File: bench/ifc_seq.sv */
`timescale 1ns/1ps
// sequencer model: rung enables and source pair
module ifc_seq (
  input  wire logic   i_clock,
  output logic [1:0]  o_en,
  output logic [31:0] o_src
);
  initial {o_en, o_src} = '0;
  // one scan, driven just after the edge
  task automatic scan(input logic [1:0] en, input logic [31:0] v);
    @(posedge i_clock);
    o_en <= en;
    o_src <= v;
  endtask
endmodule

/* File: bench/ifc_top_checker.sv */
`timescale 1ns/1ps
module ifc_top_checker
  import ifc_pkg::*;
#(parameter int unsigned P_WORD_W = WORD_W)
(
  input wire logic                i_clock, i_rstn, i_fixed_to_float_op, i_float_to_fixed_op, o_dst_we, o_exec,
  input wire logic [P_WORD_W-1:0] i_src_lo, i_src_hi, o_dst_lo, o_dst_hi
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  // joined pairs, exponent and single-enable decode
  wire [31:0] s = {i_src_hi, i_src_lo}, d = {o_dst_hi, o_dst_lo};
  wire [7:0]  e = s[30:23];
  wire        f = i_fixed_to_float_op & ~i_float_to_fixed_op, x = i_float_to_fixed_op & ~i_fixed_to_float_op;
  exec_float_a: assert property (f |=> o_exec) else $error("no exec");
  exec_fixed_a: assert property (x |=> o_exec && o_dst_we) else $error("no exec");
  idle_exec_a: assert property (!f && !x |=> !o_exec && !o_dst_we) else $error("exec idle");
  idle_hold_a: assert property (!f && !x |=> $stable(d)) else $error("dst moved");
  zero_float_a: assert property (f && s == 0 |=> d == 0) else $error("zero");
  trunc_small_a: assert property (x && e < 8'h7f |=> d == 0) else $error("frac");
  sat_high_a: assert property (x && !s[31] && e >= 8'h9e |=> d == SAT_MAX) else $error("sat max");
  sat_low_a: assert property (x && s[31] && e >= 8'h9e |=> d == SAT_MIN) else $error("sat min");
endmodule
bind ifc_top ifc_top_checker #(.P_WORD_W(P_WORD_W)) chk_u (.i_clock, .i_rstn, .i_fixed_to_float_op,
  .i_float_to_fixed_op, .o_dst_we, .o_exec, .i_src_lo, .i_src_hi, .o_dst_lo, .o_dst_hi);

/* File: bench/tb_ifc_top.sv */
`timescale 1ns/1ps
module tb_ifc_top;
  import ifc_pkg::*;
  `define CHK(a,b) begin cmp_count++; if ((a)!==(b)) begin num_errors++; $display("[FAIL] %0t mismatch got %h want %h",$time,a,b); end end
  logic        clk = 0, rstn = 0, we, ex;
  logic [1:0]  en;
  logic [31:0] src;
  logic [15:0] dlo, dhi;
  int          num_errors = 0, cmp_count = 0;
  // 40 MHz clock
  initial forever #12.5 clk = ~clk;
  ifc_seq seq_u (.i_clock(clk), .o_en(en), .o_src(src));
  ifc_top dut_u (.i_clock(clk), .i_rstn(rstn), .i_fixed_to_float_op(en[0]), .i_float_to_fixed_op(en[1]),
    .i_src_lo(src[15:0]), .i_src_hi(src[31:16]), .o_dst_lo(dlo), .o_dst_hi(dhi), .o_dst_we(we), .o_exec(ex));
  // one scan, answer checked one edge later
  task automatic run(input logic [1:0] m, input logic [31:0] v, d, input logic e);
    seq_u.scan(m, v);
    @(posedge clk);
    #1;
    `CHK({dhi, dlo}, d)
    `CHK({we, ex}, {e, e})
  endtask
  task automatic t_to_float();
    run(2'h1, 32'h1e240, 32'h47f12000, 1);
    run(2'h1, 32'h80000000, 32'hcf000000, 1);
    run(2'h1, 32'h7fffffff, 32'h4effffff, 1);
    run(2'h1, 32'h0, 32'h0, 1);
  endtask
  task automatic t_to_fixed();
    run(2'h2, 32'h47f12000, 32'h1e240, 1);
    run(2'h2, 32'hc0300000, 32'hfffffffe, 1);
    run(2'h2, 32'h3f000000, 32'h0, 1);
    run(2'h2, 32'hcf400000, SAT_MIN, 1);
    run(2'h2, 32'h4f000000, SAT_MAX, 1);
    run(2'h2, 32'h4effffff, SAT_MAX, 1);
  endtask
  task automatic t_idle();
    run(2'h0, 32'h12345678, SAT_MAX, 0);
    run(2'h3, 32'h3f800000, SAT_MAX, 0);
  endtask
  // reset in mid-run clears a written pair, then the block works again
  task automatic t_reset();
    run(2'h1, 32'h1e240, 32'h47f12000, 1);
    seq_u.scan(2'h0, 32'h0);
    rstn <= 1'b0;
    @(posedge clk);
    #1;
    `CHK({dhi, dlo, we, ex}, 34'h0)
    @(posedge clk);
    rstn <= 1'b1;
    run(2'h0, 32'h1e240, 32'h0, 0);
    run(2'h1, 32'h1e240, 32'h47f12000, 1);
  endtask
  task automatic final_report();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // reset, then the scenarios
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1;
    t_to_float();
    t_to_fixed();
    t_idle();
    t_reset();
    final_report();
  end
  // watchdog well past the forty or so cycles of scans
  initial begin
    #5000;
    num_errors++;
    final_report();
  end
endmodule

/* File: logic/ifc_convert.sv */
`timescale 1ns/1ps
// combinational float-to-integer core
module ifc_convert
  import ifc_pkg::*;
(
  // operation
  input  wire logic              i_to_fixed,
  input  wire logic [VAL_W-1:0]  i_value,
  // result
  output logic      [VAL_W-1:0]  o_result
);
  logic [VAL_W-1:0] shifted;
  logic [7:0]       exp_v;
  logic [VAL_W-1:0] full;
  logic [7:0]       shamt;

  // float to fixed; the result stays zero while the other direction runs
  always_comb begin
    shifted  = '0;
    exp_v    = '0;
    full     = '0;
    shamt    = '0;
    o_result = '0;
    if (i_to_fixed) begin
      // single precision source fields
      exp_v = i_value[EXP_LSB +: EXP_W];
      full  = {1'b1, i_value[FRAC_W-1:0], 8'h00};
      if (exp_v < EXP_BIAS) begin
        o_result = '0; // magnitude below one truncates to zero
      end else if (exp_v >= EXP_2P31) begin
        // clamp at the fixed limits
        o_result = i_value[SIGN_POS] ? SAT_MIN : SAT_MAX;
      end else begin
        shamt    = EXP_2P31 - exp_v;
        shifted  = full >> shamt[4:0]; // fraction bits dropped
        o_result = i_value[SIGN_POS] ? (~shifted + 32'h1) : shifted;
      end
    end
  end
endmodule

/* File: logic/ifc_pkg.sv */
package ifc_pkg;
  // word and value geometry
  localparam int unsigned WORD_W    = 16;
  localparam int unsigned VAL_W     = 32;
  // single precision field layout
  localparam int unsigned EXP_W     = 8;
  localparam int unsigned FRAC_W    = 23;
  localparam int unsigned SIGN_POS  = 31;
  localparam int unsigned EXP_LSB   = 23;
  localparam logic [7:0]  EXP_BIAS  = 8'h7f;
  // float-to-integer limits
  localparam logic [31:0] SAT_MIN   = 32'h80000000;
  localparam logic [31:0] SAT_MAX   = 32'h7fffff80;
  localparam logic [7:0]  EXP_2P31  = 8'h9e;
  // operation select
  typedef enum logic [1:0] {
    IFC_OP_TO_FLOAT = 2'b01,
    IFC_OP_TO_FIXED = 2'b10
  } ifc_op_type;
  // completion sequencer states
  typedef enum logic [1:0] {
    IFC_ST_IDLE = 2'b01,
    IFC_ST_DONE = 2'b10
  } ifc_state_type;
endpackage

/* File: logic/ifc_top.sv */
`timescale 1ns/1ps
module ifc_top
  import ifc_pkg::*;
#(
  parameter int unsigned P_WORD_W = WORD_W
)
(
  // clock and reset
  input  wire logic                i_clock,
  input  wire logic                i_rstn,
  // rung enables
  input  wire logic                i_fixed_to_float_op,
  input  wire logic                i_float_to_fixed_op,
  // source word pair
  input  wire logic [P_WORD_W-1:0] i_src_lo,
  input  wire logic [P_WORD_W-1:0] i_src_hi,
  // destination word pair and write strobe
  output logic      [P_WORD_W-1:0] o_dst_lo,
  output logic      [P_WORD_W-1:0] o_dst_hi,
  output logic                     o_dst_we,
  // execution output
  output logic                     o_exec
);
  // width of a bit index into one value
  localparam int unsigned LEAD_W = $clog2(VAL_W);

  // operand pairing and operation decode
  logic [VAL_W-1:0]    src_word;
  ifc_op_type          op_sel;
  logic                go;
  logic                to_fixed;
  // integer-to-float path
  logic                flt_sign;
  logic [VAL_W-1:0]    mag;
  logic                src_zero;
  logic [LEAD_W-1:0]   lead;
  logic [VAL_W-1:0]    norm;
  logic [EXP_W-1:0]    flt_exp;
  logic [FRAC_W-1:0]   flt_frac;
  logic [VAL_W-1:0]    flt_word;
  // float-to-integer path and result select
  logic [VAL_W-1:0]    fix_word;
  logic [VAL_W-1:0]    result;
  // destination group
  logic [P_WORD_W-1:0] dst_lo_ff;
  logic [P_WORD_W-1:0] nxt_dst_lo;
  logic [P_WORD_W-1:0] dst_hi_ff;
  logic [P_WORD_W-1:0] nxt_dst_hi;
  // strobe group
  logic                we_ff;
  logic                nxt_we;
  logic                exec_ff;
  logic                nxt_exec;
  // sequencer group
  ifc_state_type       state_ff;
  ifc_state_type       nxt_state;

  // pair source words into one value, upper half from the high word
  assign src_word = {i_src_hi, i_src_lo};

  // decode the rung enables; both high or both low executes nothing
  always_comb begin
    op_sel = IFC_OP_TO_FLOAT;
    go     = 1'b0;
    case ({i_float_to_fixed_op, i_fixed_to_float_op})
      2'h1: begin
        op_sel = IFC_OP_TO_FLOAT;
        go     = 1'b1;
      end
      2'h2: begin
        op_sel = IFC_OP_TO_FIXED;
        go     = 1'b1;
      end
      // anything but exactly one enable runs nothing
      default: begin
        op_sel = IFC_OP_TO_FLOAT;
        go     = 1'b0;
      end
    endcase
  end

  // the float-to-integer core only works while its direction is picked
  assign to_fixed = (op_sel == IFC_OP_TO_FIXED);

  // the sign passes straight into the float
  assign flt_sign = src_word[SIGN_POS];

  // integer to float, step one: magnitude and position of the leading one
  always_comb begin
    mag  = src_word;
    lead = '0;
    // magnitude of a negative source by two's complement
    if (flt_sign) begin
      mag = ~src_word + VAL_W'(1); // the most negative value maps onto itself
    end
    // the highest set bit wins, so the scan runs from the bottom up
    for (int i = 0; i < VAL_W; i++) begin
      if (mag[i]) begin
        lead = LEAD_W'(i);
      end
    end
  end

  // zero has no leading one and needs its own encoding
  assign src_zero = (mag == '0);

  // integer to float, step two: normalise and pack the fields
  always_comb begin
    norm     = mag << (LEAD_W'(VAL_W - 1) - lead);
    flt_exp  = EXP_BIAS + EXP_W'(lead);
    // the hidden leading one sits at the top bit and is not stored
    flt_frac = norm[VAL_W-2 -: FRAC_W];
    flt_word = '0;
    // bits below the fraction field are dropped, not rounded
    if (!src_zero) begin
      flt_word = {flt_sign, flt_exp, flt_frac};
    end
  end

  // float to integer: clamp and truncation live in the core
  ifc_convert u_convert (
    .i_to_fixed (to_fixed),
    .i_value    (src_word),
    .o_result   (fix_word)
  );

  // pick the value of the direction that executes
  always_comb begin
    result = flt_word;
    unique case (op_sel)
      IFC_OP_TO_FLOAT: result = flt_word;
      IFC_OP_TO_FIXED: result = fix_word;
      default:         result = flt_word;
    endcase
  end

  // destination group: written only by an executed scan, held otherwise
  always_comb begin
    // default: hold the stored pair
    nxt_dst_lo = dst_lo_ff;
    nxt_dst_hi = dst_hi_ff;
    if (go) begin
      nxt_dst_lo = result[P_WORD_W-1:0];        // lower word
      nxt_dst_hi = result[VAL_W-1 -: P_WORD_W]; // upper word
    end
  end

  // destination registers
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      dst_lo_ff <= '0;
      dst_hi_ff <= '0;
    end else begin
      dst_lo_ff <= nxt_dst_lo;
      dst_hi_ff <= nxt_dst_hi;
    end
  end

  // sequencer group: done for the cycle after every executed scan
  always_comb begin
    nxt_state = IFC_ST_IDLE;
    unique case (state_ff)
      IFC_ST_IDLE: begin
        // an executed scan moves to done
        if (go) begin
          nxt_state = IFC_ST_DONE;
        end
      end
      IFC_ST_DONE: begin
        // back to back scans stay in done
        if (go) begin
          nxt_state = IFC_ST_DONE;
        end else begin
          nxt_state = IFC_ST_IDLE;
        end
      end
      default: nxt_state = IFC_ST_IDLE; // an illegal code falls back to idle
    endcase
  end

  // sequencer register
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      state_ff <= IFC_ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // strobe group: both strobes mark the done state
  always_comb begin
    nxt_we   = (nxt_state == IFC_ST_DONE);
    nxt_exec = (nxt_state == IFC_ST_DONE); // low while nothing executes
  end

  // strobe registers
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      we_ff   <= 1'b0;
      exec_ff <= 1'b0;
    end else begin
      we_ff   <= nxt_we;
      exec_ff <= nxt_exec;
    end
  end

  // outputs come straight from the registers
  assign o_dst_lo = dst_lo_ff;
  assign o_dst_hi = dst_hi_ff;
  assign o_dst_we = we_ff;
  assign o_exec   = exec_ff;
endmodule
